// *** rtl/ccpwm_consts.vh ***
// Constants for the capture, compare and PWM unit
`ifndef CCPWM_CONSTS_VH
`define CCPWM_CONSTS_VH
// Register byte offsets
`define CCPWM_OFS_LOW      8'h00
`define CCPWM_OFS_HIGH     8'h04
`define CCPWM_OFS_CTRL     8'h08
`define CCPWM_OFS_TCFG     8'h0C
`define CCPWM_OFS_PERIOD   8'h10
`define CCPWM_OFS_STATUS   8'h14
`define CCPWM_OFS_TCOUNT   8'h18
`define CCPWM_OFS_DEAD     8'h1C
// Reset values
`define CCPWM_RST_CTRL     8'h00
`define CCPWM_RST_PERIOD   8'hFF
`define CCPWM_RST_TCFG     4'h0
// Module control field positions
`define CCPWM_CFG_HI       7
`define CCPWM_CFG_LO       6
`define CCPWM_DLB_HI       5
`define CCPWM_DLB_LO       4
`define CCPWM_MODE_HI      3
`define CCPWM_MODE_LO      0
// Timer config field positions
`define CCPWM_TSEL_BIT     0
`define CCPWM_PSC_HI       2
`define CCPWM_PSC_LO       1
`define CCPWM_TON_BIT      3
// Status field positions
`define CCPWM_FLAG_BIT     0
`define CCPWM_IEN_BIT      1
// Mode field codes
`define CCPWM_MODE_OFF     4'h0
`define CCPWM_MODE_TOGGLE  4'h2
`define CCPWM_MODE_CAP_FE  4'h4
`define CCPWM_MODE_CAP_RE  4'h5
`define CCPWM_MODE_CAP_R4  4'h6
`define CCPWM_MODE_CAP_R16 4'h7
`define CCPWM_MODE_SET     4'h8
`define CCPWM_MODE_CLR     4'h9
`define CCPWM_MODE_SWI     4'hA
`define CCPWM_MODE_SPEC    4'hB
// Output configuration codes
`define CCPWM_OC_SINGLE    2'h0
`define CCPWM_OC_FULL_FWD  2'h1
`define CCPWM_OC_HALF      2'h2
`define CCPWM_OC_FULL_REV  2'h3
// Clocks per period timer tick minus one, per period timer prescale
`define CCPWM_SUB_LIM1     6'h03
`define CCPWM_SUB_LIM4     6'h0F
`define CCPWM_SUB_LIM16    6'h3F
// AXI responses
`define CCPWM_RESP_OKAY    2'h0
`define CCPWM_RESP_SLVERR  2'h2
`endif

// *** rtl/ccpwm_unit.v ***
// Capture, compare and enhanced PWM unit with an AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "ccpwm_consts.vh"

module ccpwm_unit #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Timer bases and port state, same clock
  input  wire [15:0]       first_timer_count,
  input  wire [15:0]       third_timer_count,
  input  wire              port_direction_out,
  input  wire              port_data_out,
  // Module pin input, asynchronous
  input  wire              module_pin_in,
  // Timer and converter triggers, and the module flag
  output reg               first_timer_reset,
  output reg               third_timer_reset,
  output reg               converter_go,
  output wire              module_flag,
  // Output pins, enable low while driving
  output reg  [3:0]        pwm_pin_out,
  output reg  [3:0]        pwm_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg  [7:0]  ccp_low_reg;
  reg  [7:0]  ccp_high_reg;
  reg  [7:0]  ctrl_reg;
  reg  [3:0]  tcfg_reg;
  reg  [7:0]  period_reg;
  reg         flag_reg;
  reg         ien_reg;
  reg  [7:0]  period_timer_count_reg;
  reg  [5:0]  sub_reg;
  reg  [6:0]  dead_set_reg;
  reg  [6:0]  dead_act_reg;
  reg  [1:0]  duty_lat_reg;
  reg  [3:0]  ocfg_buf_reg;
  reg         pwm_raw_reg;
  reg         cmp_latch_reg;
  reg         match_q_reg;
  reg  [3:0]  psc_cnt_reg;
  reg         pin_s1_reg;
  reg         pin_s2_reg;
  reg         src_q_reg;
  reg  [ADDR_W-1:0] aw_addr_reg;
  reg         aw_have_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_have_reg;

  wire [3:0]  mode = ctrl_reg[`CCPWM_MODE_HI:`CCPWM_MODE_LO];
  wire        is_pwm = (mode[3:2] == 2'b11);
  wire        is_cap = (mode[3:2] == 2'b01);
  wire        is_cmp = (mode == `CCPWM_MODE_TOGGLE) || (mode[3:2] == 2'b10);
  wire [15:0] sel_timer = tcfg_reg[`CCPWM_TSEL_BIT] ?
                          third_timer_count : first_timer_count;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus handshake
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire        wr_hit = (aw_addr_reg[ADDR_W-1:5] == 0);
  wire [7:0]  wr_ofs = {3'b000, aw_addr_reg[4:2], 2'b00};
  wire        wr_b0 = wr_go && wr_hit && w_strb_reg[0];
  wire        wr_b1 = wr_go && wr_hit && w_strb_reg[1];
  wire [7:0]  wd0 = w_data_reg[7:0];
  wire        wr_low    = wr_b0 && (wr_ofs == `CCPWM_OFS_LOW);
  wire        wr_high   = wr_b0 && (wr_ofs == `CCPWM_OFS_HIGH);
  wire        wr_ctrl   = wr_b0 && (wr_ofs == `CCPWM_OFS_CTRL);
  wire        wr_tcfg   = wr_b0 && (wr_ofs == `CCPWM_OFS_TCFG);
  wire        wr_period = wr_b0 && (wr_ofs == `CCPWM_OFS_PERIOD);
  wire        wr_status = wr_b0 && (wr_ofs == `CCPWM_OFS_STATUS);
  wire        wr_dead   = wr_b0 && (wr_ofs == `CCPWM_OFS_DEAD);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg  <= {ADDR_W{1'b0}};
      aw_have_reg  <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      w_have_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CCPWM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (wr_go) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `CCPWM_RESP_OKAY : `CCPWM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  wire [7:0]  rd_ofs = {3'b000, s_axi_araddr[4:2], 2'b00};
  wire        rd_hit = (s_axi_araddr[ADDR_W-1:5] == 0);
  reg  [31:0] rdata_next;

  always @* begin
    rdata_next = 32'h00000000;
    case (rd_ofs)
      `CCPWM_OFS_LOW:    rdata_next[7:0] = ccp_low_reg;
      `CCPWM_OFS_HIGH:   rdata_next[7:0] = ccp_high_reg;
      `CCPWM_OFS_CTRL:   rdata_next[7:0] = ctrl_reg;
      `CCPWM_OFS_TCFG:   rdata_next[3:0] = tcfg_reg;
      `CCPWM_OFS_PERIOD: rdata_next[7:0] = period_reg;
      `CCPWM_OFS_STATUS: rdata_next[1:0] = {ien_reg, flag_reg};
      `CCPWM_OFS_TCOUNT: rdata_next[7:0] = period_timer_count_reg;
      `CCPWM_OFS_DEAD:   rdata_next[14:0] = {dead_act_reg, 1'b0,
                                             dead_set_reg};
      default:           rdata_next = 32'h00000000;
    endcase
    if (!rd_hit) begin
      rdata_next = 32'h00000000;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `CCPWM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_next;
      s_axi_rresp  <= rd_hit ? `CCPWM_RESP_OKAY : `CCPWM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture source and prescaler
  // A driven pin reflects the port data, so port writes reach the edge logic
  wire src = port_direction_out ? port_data_out : pin_s2_reg;
  wire rise = src && !src_q_reg;
  wire fall = !src && src_q_reg;
  reg  cap_evt;

  always @* begin
    case (mode)
      `CCPWM_MODE_CAP_FE:  cap_evt = fall;
      `CCPWM_MODE_CAP_RE:  cap_evt = rise;
      `CCPWM_MODE_CAP_R4:  cap_evt = rise && (psc_cnt_reg[1:0] == 2'h3);
      `CCPWM_MODE_CAP_R16: cap_evt = rise && (psc_cnt_reg == 4'hF);
      default:             cap_evt = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_reg  <= 1'b0;
      pin_s2_reg  <= 1'b0;
      src_q_reg   <= 1'b0;
      psc_cnt_reg <= 4'h0;
    end else begin
      pin_s1_reg <= module_pin_in;
      pin_s2_reg <= pin_s1_reg;
      src_q_reg  <= src;
      if (!is_cap) begin
        psc_cnt_reg <= 4'h0;
      end else if (rise) begin
        // Kept across capture mode changes, so a switch may fire early
        psc_cnt_reg <= psc_cnt_reg + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare
  // The timer must advance on this clock for the match to be seen
  wire match = ({ccp_high_reg, ccp_low_reg} == sel_timer);
  wire cmp_evt = is_cmp && match && !match_q_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      match_q_reg       <= 1'b0;
      cmp_latch_reg     <= 1'b0;
      first_timer_reset <= 1'b0;
      third_timer_reset <= 1'b0;
      converter_go      <= 1'b0;
    end else begin
      match_q_reg <= is_cmp && match;
      if (wr_ctrl && (wd0 == 8'h00)) begin
        cmp_latch_reg <= 1'b0;
      end else if (mode == `CCPWM_MODE_OFF) begin
        cmp_latch_reg <= 1'b0;
      end else if (cmp_evt) begin
        case (mode)
          `CCPWM_MODE_TOGGLE: cmp_latch_reg <= !cmp_latch_reg;
          `CCPWM_MODE_SET:    cmp_latch_reg <= 1'b1;
          `CCPWM_MODE_CLR:    cmp_latch_reg <= 1'b0;
          default:            cmp_latch_reg <= cmp_latch_reg;
        endcase
      end
      first_timer_reset <= cmp_evt && (mode == `CCPWM_MODE_SPEC) &&
                           !tcfg_reg[`CCPWM_TSEL_BIT];
      third_timer_reset <= cmp_evt && (mode == `CCPWM_MODE_SPEC) &&
                           tcfg_reg[`CCPWM_TSEL_BIT];
      converter_go <= cmp_evt && (mode == `CCPWM_MODE_SPEC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period timer with prescaler and two-bit phase extension
  wire [1:0] psc = tcfg_reg[`CCPWM_PSC_HI:`CCPWM_PSC_LO];
  wire [5:0] sub_lim = (psc == 2'b00) ? `CCPWM_SUB_LIM1 :
                       (psc == 2'b01) ? `CCPWM_SUB_LIM4 : `CCPWM_SUB_LIM16;
  wire [1:0] ext = (psc == 2'b00) ? sub_reg[1:0] :
                   (psc == 2'b01) ? sub_reg[3:2] : sub_reg[5:4];
  wire       tick = tcfg_reg[`CCPWM_TON_BIT] && (sub_reg >= sub_lim);
  wire       per_start = tick && (period_timer_count_reg == period_reg);
  wire [9:0] duty_new = {ccp_low_reg, ctrl_reg[`CCPWM_DLB_HI:`CCPWM_DLB_LO]};
  // Never true when duty exceeds the period, so the output stays set
  // Clear is decided one clock ahead so the registered output is exact
  wire       sub_last = (psc == 2'b00) ? 1'b1 :
                        (psc == 2'b01) ? (sub_reg[1:0] == 2'h3) :
                        (sub_reg[3:0] == 4'hF);
  wire [9:0] pos_next = {period_timer_count_reg, ext} + 10'h001;
  wire       duty_hit = sub_last && ({ccp_high_reg, duty_lat_reg} ==
                        pos_next);

  always @(posedge aclk) begin
    if (!aresetn) begin
      sub_reg  <= 6'h00;
      period_timer_count_reg <= 8'h00;
    end else begin
      // No postscaler exists in this path
      if (!tcfg_reg[`CCPWM_TON_BIT] || (sub_reg >= sub_lim)) begin
        sub_reg <= 6'h00;
      end else begin
        sub_reg <= sub_reg + 6'h01;
      end
      if (per_start) begin
        period_timer_count_reg <= 8'h00;
      end else if (tick) begin
        period_timer_count_reg <= period_timer_count_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM generation and buffering
  always @(posedge aclk) begin
    if (!aresetn) begin
      pwm_raw_reg  <= 1'b0;
      duty_lat_reg <= 2'h0;
      ocfg_buf_reg <= 4'h0;
      dead_act_reg <= 7'h00;
    end else begin
      if (!is_pwm) begin
        pwm_raw_reg <= 1'b0;
      end else if (per_start) begin
        pwm_raw_reg <= (duty_new != 10'h000);
      end else if (duty_hit) begin
        pwm_raw_reg <= 1'b0;
      end
      if (is_pwm && per_start) begin
        duty_lat_reg <= ctrl_reg[`CCPWM_DLB_HI:`CCPWM_DLB_LO];
        ocfg_buf_reg <= {ctrl_reg[`CCPWM_CFG_HI:`CCPWM_CFG_LO],
                         mode[1:0]};
      end
      if (is_pwm && (per_start || duty_hit)) begin
        dead_act_reg <= dead_set_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin steering
  wire [1:0] oc = ocfg_buf_reg[3:2];
  reg  [3:0] lvl;
  reg  [3:0] drv;

  always @* begin
    lvl = 4'h0;
    drv = 4'h0;
    if (is_pwm) begin
      case (oc)
        `CCPWM_OC_SINGLE: begin
          lvl = {3'b000, pwm_raw_reg};
          drv = 4'b0001;
        end
        `CCPWM_OC_HALF: begin
          lvl = {2'b00, !pwm_raw_reg, pwm_raw_reg};
          drv = 4'b0011;
        end
        `CCPWM_OC_FULL_FWD: begin
          lvl = {pwm_raw_reg, 3'b001};
          drv = 4'b1111;
        end
        default: begin
          lvl = {2'b01, pwm_raw_reg, 1'b0};
          drv = 4'b1111;
        end
      endcase
      // Pair a/c follows bit 1, pair b/d bit 0; set means active low
      lvl = lvl ^ {ocfg_buf_reg[0], ocfg_buf_reg[1],
                   ocfg_buf_reg[0], ocfg_buf_reg[1]};
    end else if (is_cmp && (mode != `CCPWM_MODE_SWI) &&
                 (mode != `CCPWM_MODE_SPEC)) begin
      lvl = {3'b000, cmp_latch_reg};
      drv = 4'b0001;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pwm_pin_out  <= 4'h0;
      pwm_pin_oe_n <= 4'hF;
    end else begin
      pwm_pin_out  <= lvl & drv;
      pwm_pin_oe_n <= ~drv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and flag
  wire flag_clr = wr_status && wd0[`CCPWM_FLAG_BIT];
  // Only true events set the flag; a set beats a clear in the same cycle
  wire flag_set = cap_evt || cmp_evt;
  assign module_flag = flag_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ccp_low_reg  <= 8'h00;
      ccp_high_reg <= 8'h00;
      ctrl_reg     <= `CCPWM_RST_CTRL;
      tcfg_reg     <= `CCPWM_RST_TCFG;
      period_reg   <= `CCPWM_RST_PERIOD;
      flag_reg     <= 1'b0;
      ien_reg      <= 1'b0;
      dead_set_reg <= 7'h00;
    end else begin
      if (wr_low) begin
        ccp_low_reg <= wd0;
      end
      if (wr_high && !is_pwm) begin
        ccp_high_reg <= wd0;
      end
      if (cap_evt) begin
        {ccp_high_reg, ccp_low_reg} <= sel_timer;
      end else if (is_pwm && per_start) begin
        ccp_high_reg <= ccp_low_reg;
      end
      if (wr_ctrl) begin
        ctrl_reg <= wd0;
      end
      if (wr_tcfg) begin
        tcfg_reg <= wd0[3:0];
      end
      if (wr_period) begin
        period_reg <= wd0;
      end
      if (wr_status) begin
        ien_reg <= wd0[`CCPWM_IEN_BIT];
      end
      if (wr_dead) begin
        dead_set_reg <= wd0[6:0];
      end
      if (flag_set) begin
        flag_reg <= 1'b1;
      end else if (flag_clr) begin
        flag_reg <= 1'b0;
      end
    end
  end

endmodule // ccpwm_unit

// *** verification/ccpwm_pin_source.sv ***
// External signal source driving the module pin
`timescale 1ns/10ps
module ccpwm_pin_source (
  // Driven pin
  output logic module_pin_in
);
  initial module_pin_in = 1'b0;
  // Half period off the clock grid, so phase is unrelated to the bench
  task automatic pulses(input int n);
    repeat (n) begin
      #23.3 module_pin_in = 1'b1;
      #23.3 module_pin_in = 1'b0;
    end
  endtask
endmodule // ccpwm_pin_source

// *** verification/ccpwm_unit_assertions.sv ***
// Port-level checks of the capture, compare and PWM unit
`timescale 1ns/10ps
`include "ccpwm_consts.vh"
module ccpwm_unit_assertions (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Triggers and flag
  input wire        first_timer_reset,
  input wire        third_timer_reset,
  input wire        converter_go,
  input wire        module_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  a_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_bresp_legal: assert property (s_axi_bvalid |->
    s_axi_bresp == `CCPWM_RESP_OKAY || s_axi_bresp == `CCPWM_RESP_SLVERR)
    else $error("bad write response");
  a_trig_pulse: assert property (
    first_timer_reset || third_timer_reset |=>
    !first_timer_reset && !third_timer_reset) else $error("long trigger");
  a_go_with_reset: assert property (
    converter_go == (first_timer_reset || third_timer_reset))
    else $error("conversion start apart from timer reset");
  a_one_timer: assert property (
    !(first_timer_reset && third_timer_reset)) else $error("both timers");
  a_flag_sw_clear: assert property (
    $fell(module_flag) |-> s_axi_wvalid || $past(s_axi_wvalid) ||
    $past(s_axi_wvalid, 2)) else $error("flag cleared by hardware");
  c_flag: cover property ($rose(module_flag));
  c_third: cover property (third_timer_reset);
  c_slverr: cover property (s_axi_rvalid &&
    s_axi_rresp == `CCPWM_RESP_SLVERR);
endmodule // ccpwm_unit_assertions

bind ccpwm_unit ccpwm_unit_assertions ccpwm_unit_assertions_i (.aclk,
  .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .first_timer_reset, .third_timer_reset, .converter_go, .module_flag);

// *** verification/ccpwm_unit_tb.sv ***
// Self-checking bench for the capture, compare and PWM unit
`timescale 1ns/10ps
`include "ccpwm_consts.vh"
module ccpwm_unit_tb;
  localparam logic [7:0] LO = `CCPWM_OFS_LOW, HI = `CCPWM_OFS_HIGH;
  localparam logic [7:0] CT = `CCPWM_OFS_CTRL, TC = `CCPWM_OFS_TCFG;
  localparam logic [7:0] PR = `CCPWM_OFS_PERIOD, ST = `CCPWM_OFS_STATUS;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [15:0] first_timer_count = 0, third_timer_count = 0, v;
  logic        port_direction_out = 0, port_data_out = 0, e, last;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, module_pin_in, first_timer_reset;
  wire         third_timer_reset, converter_go, module_flag;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [3:0]   pwm_pin_out, pwm_pin_oe_n;
  logic [31:0] d;
  logic [1:0]  rsp;
  logic [15:0] expq [$];
  int          fails = 0, comparisons = 0, seed = 14, n, h, r;
  always #2 aclk = ~aclk;
  ccpwm_unit ccpwm_unit_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .first_timer_count, .third_timer_count,
    .port_direction_out, .port_data_out, .module_pin_in, .first_timer_reset,
    .third_timer_reset, .converter_go, .module_flag, .pwm_pin_out,
    .pwm_pin_oe_n);
  ccpwm_pin_source ccpwm_pin_source_i (.module_pin_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic guard(input int k);
    if (k > 300) begin
      fails++;
      $display("FAIL wait expected answer seen timeout");
      conclude();
    end
  endtask
  // Offers address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    int k = 0;
    bit ta = 0, tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      guard(k++);
      if (!ta && s_axi_awready === 1'b1) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready === 1'b1) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(k++);
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    int k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      guard(k++);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(k++);
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Pin edges from the source, then the flag as software sees it
  task automatic pc(input int k, input logic f);
    ccpwm_pin_source_i.pulses(k);
    repeat (8) @(posedge aclk);
    rd(ST, d);
    chk("flag", 32'(d[0]), 32'(f));
  endtask
  // Two captures with no read between; only the newer value survives
  task automatic cap(input logic [3:0] m, input int k, input logic s);
    logic [31:0] lo;
    wr(CT, 32'h0);
    wr(TC, 32'(s));
    wr(CT, 32'(m));
    repeat (2) begin
      v = 16'($random(seed));
      if (s)
        third_timer_count <= v;
      else
        first_timer_count <= v;
      expq.push_back(v);
      wr(ST, 32'h1);
      if (k > 1)
        pc(k - 1, 1'b0);
      pc(1, 1'b1);
    end
    void'(expq.pop_front());
    rd(LO, lo);
    rd(HI, d);
    chk("capture pair", {d[7:0], lo[7:0]}, expq.pop_front());
  endtask
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] cmod [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
  int         ccnt [4] = '{1, 1, 4, 16};
  logic [3:0] kmod [5] = '{4'h8, 4'hA, 4'h2, 4'h9, 4'h2};
  int         pd [5] = '{6, 0, 1020, 6, 6};
  logic [3:0] pm [5] = '{4'hC, 4'hC, 4'hC, 4'hE, 4'hC};
  logic [3:0] pt [5] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'hA};
  int         ph [5] = '{24, 0, 64, 40, 24};
  int         pr [5] = '{4, 0, 0, 4, 1};
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CT, d);
    chk("control reset", d, 32'h0);
    rd(PR, d);
    chk("period reset", d, 32'hFF);
    rd(8'h20, d);
    chk("unmapped read", 32'(rsp), 32'(`CCPWM_RESP_SLVERR));
    wr(8'h20, 32'h1);
    chk("unmapped write", 32'(rsp), 32'(`CCPWM_RESP_SLVERR));
    $display("test registers done");
    foreach (cmod[i])
      cap(cmod[i], ccnt[i], i[0]);
    wr(CT, 32'h0);
    wr(CT, 32'h6);
    wr(ST, 32'h1);
    pc(2, 1'b0);
    wr(CT, 32'h0);
    wr(CT, 32'h6);
    pc(3, 1'b0);
    pc(1, 1'b1);
    wr(ST, 32'h1);
    pc(2, 1'b0);
    wr(CT, 32'h7);
    wr(ST, 32'h1);
    pc(9, 1'b0);
    pc(1, 1'b1);
    wr(CT, 32'h5);
    wr(ST, 32'h1);
    port_direction_out <= 1'b1;
    @(posedge aclk);
    port_data_out <= 1'b1;
    pc(0, 1'b1);
    port_direction_out <= 1'b0;
    port_data_out <= 1'b0;
    $display("test capture done");
    e = 1'b0;
    wr(TC, 32'h0);
    foreach (kmod[i]) begin
      v = 16'($random(seed)) | 16'h1;
      first_timer_count <= 16'h0;
      wr(CT, 32'(kmod[i]));
      wr(LO, 32'(v[7:0]));
      wr(HI, 32'(v[15:8]));
      wr(ST, 32'h1);
      first_timer_count <= v;
      repeat (6) @(posedge aclk);
      e = kmod[i] == 4'h8 ? 1'b1 : kmod[i] == 4'h9 ? 1'b0 :
          kmod[i] == 4'h2 ? ~e : e;
      if (kmod[i] != 4'hA)
        chk("compare pin", 32'(pwm_pin_out[0]), 32'(e));
      rd(ST, d);
      chk("compare flag", 32'(d[0]), 32'h1);
    end
    wr(CT, 32'h0);
    repeat (3) @(posedge aclk);
    chk("latch cleared", 32'(pwm_pin_out[0]), 32'h0);
    for (int s = 0; s < 2; s++) begin
      first_timer_count <= 16'h0;
      third_timer_count <= 16'h0;
      wr(TC, 32'(s));
      wr(CT, 32'hB);
      wr(LO, 32'h34);
      wr(HI, 32'h12);
      if (s)
        third_timer_count <= 16'h1234;
      else
        first_timer_count <= 16'h1234;
      n = 0;
      while (converter_go !== 1'b1) begin
        @(posedge aclk);
        guard(n++);
      end
      chk("timer reset", {first_timer_reset, third_timer_reset},
          s ? 32'h1 : 32'h2);
    end
    $display("test compare done");
    wr(CT, 32'h0);
    wr(PR, 32'h3);
    foreach (pd[i]) begin
      wr(TC, 32'(pt[i]));
      wr(LO, 32'(pd[i] >> 2));
      wr(CT, 32'({pd[i][1:0], pm[i]}));
      repeat (200) @(posedge aclk);
      h = 0;
      r = 0;
      last = pwm_pin_out[0];
      repeat (64) begin
        @(posedge aclk);
        h += int'(pwm_pin_out[0] === 1'b1);
        r += int'(pwm_pin_out[0] === 1'b1 && last !== 1'b1);
        last = pwm_pin_out[0];
      end
      chk("pwm high cycles", h, ph[i]);
      chk("pwm periods", r, pr[i]);
    end
    chk("pwm drive", 32'(pwm_pin_oe_n), 32'hE);
    rd(HI, d);
    chk("duty buffer", d & 32'hFF, 32'h1);
    wr(HI, 32'h55);
    rd(HI, d);
    chk("duty buffer ro", d & 32'hFF, 32'h1);
    $display("test pwm done");
    conclude();
  end
endmodule // ccpwm_unit_tb
